/* rtl/dwu_pkg.sv */
// Package for the dual watchdog unit: register map, field layout, resets, timing.
// Assumes a 32-bit APB master and a single 250 MHz system clock.
package dwu_pkg;
   // Register byte offsets
   localparam logic [7:0] DWU_IND_KEY_OFS  = 8'h00;
   localparam logic [7:0] DWU_IND_PRE_OFS  = 8'h04;
   localparam logic [7:0] DWU_IND_RLD_OFS  = 8'h08;
   localparam logic [7:0] DWU_IND_STAT_OFS = 8'h0c;
   localparam logic [7:0] DWU_WIN_CTRL_OFS = 8'h10;
   localparam logic [7:0] DWU_WIN_CFG_OFS  = 8'h14;
   localparam logic [7:0] DWU_DBG_OFS      = 8'h18;
   localparam logic [7:0] DWU_INT_STAT_OFS = 8'h1c;
   localparam logic [7:0] DWU_INT_MASK_OFS = 8'h20;

   // Key codes written to the independent watchdog key register
   localparam logic [15:0] DWU_KEY_START  = 16'hcccc;
   localparam logic [15:0] DWU_KEY_RELOAD = 16'haaaa;

   // Field positions
   localparam int DWU_IND_CFG_TIMER_BIT = 12;
   localparam int DWU_WIN_EN_BIT        = 7;
   localparam int DWU_WIN_FREE_BIT      = 7;
   localparam int DWU_DBG_IND_BIT       = 0;
   localparam int DWU_DBG_WIN_BIT       = 1;
   localparam int DWU_INT_WIN_EWI_BIT   = 0;
   localparam int DWU_INT_IND_TMO_BIT   = 1;
   localparam int DWU_IND_RUN_BIT       = 12;

   // Reset values and the window early-warning count
   localparam logic [7:0]  DWU_IND_PRE_RST = 8'h00;
   localparam logic [11:0] DWU_IND_RLD_RST = 12'hfff;
   localparam logic [6:0]  DWU_WIN_CNT_RST = 7'h7f;
   localparam logic [6:0]  DWU_WIN_WIN_RST = 7'h7f;
   localparam logic [6:0]  DWU_WIN_EWI_VAL = 7'h40;

   // Timing
   localparam int DWU_SYS_CLK_MHZ   = 250;
   localparam int DWU_WIN_STEP_NS   = 16384;
   localparam int DWU_WIN_STEP_CYC  = DWU_WIN_STEP_NS * DWU_SYS_CLK_MHZ / 1000;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } dwu_apb_req_t;
endpackage

/* rtl/dwu_top.sv */
// Dual watchdog unit: independent watchdog on a low-speed tick, window watchdog on
// the system clock, APB register slave and one level interrupt.
// Assumes i_lsi_tick is a one-cycle pulse per low-speed RC period, synchronous here.
//
// Functional notes
// - Independent counter 12-bit behind 8-bit prescaler
// - Independent counter advances on RC tick only
// - Independent counter ignores low-power state
// - Independent watchdog resets or acts as timer
// - Option strap starts independent watchdog by hardware
// - Independent counter freezes on debug halt
// - Window counter 7-bit, may run freely
// - Window watchdog resets on bad service
// - Window counter runs from system clock
// - Window early warning interrupt before reset
// - Window counter freezes on debug halt
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module dwu_top
   import dwu_pkg::*;
#(
   parameter int WIN_STEP_CYC = DWU_WIN_STEP_CYC
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire dwu_apb_req_t i_apb,
   input  wire logic         i_lsi_tick,
   input  wire logic         i_hw_start_opt,
   input  wire logic         i_dbg_halt,
   input  wire logic         i_low_power,
   output logic              o_pready,
   output logic [31:0]       o_prdata,
   output logic              o_pslverr,
   output logic              o_irq,
   output logic              o_rst_req
);
   // Register state
   logic [7:0]  ind_pre_reg,   ind_pre_next;
   logic [11:0] ind_rld_reg,   ind_rld_next;
   logic        ind_timer_reg, ind_timer_next;
   logic        ind_run_reg,   ind_run_next;
   logic [7:0]  ind_psc_reg,   ind_psc_next;
   logic [11:0] ind_cnt_reg,   ind_cnt_next;
   logic        win_en_reg,    win_en_next;
   logic        win_free_reg,  win_free_next;
   logic [6:0]  win_win_reg,   win_win_next;
   logic [6:0]  win_cnt_reg,   win_cnt_next;
   logic [31:0] win_div_reg,   win_div_next;
   logic [1:0]  dbg_reg,       dbg_next;
   logic [1:0]  int_stat_reg,  int_stat_next;
   logic [1:0]  int_mask_reg,  int_mask_next;
   logic        pready_reg,    pready_next;
   logic [31:0] prdata_reg,    prdata_next;
   logic        pslverr_reg,   pslverr_next;
   logic        irq_reg,       irq_next;
   logic        rst_req_reg,   rst_req_next;

   logic       acc;
   logic       wr;
   logic       rd;
   logic       ind_tick;
   logic       win_step;
   logic [1:0] ind_ev;
   logic [1:0] win_ev;
   logic [1:0] ev_set;
   logic       ind_rst;
   logic       win_rst;
   logic       stat_clr;
   // Unpacked so each generated process owns its own element
   logic       stat_bit_next [2];

   always_comb begin
      acc = i_apb.psel & i_apb.penable & ~pready_reg;
      wr  = acc & i_apb.pwrite;
      rd  = acc & ~i_apb.pwrite;
   end

   // Independent watchdog
   always_comb begin
      ind_pre_next   = ind_pre_reg;
      ind_rld_next   = ind_rld_reg;
      ind_timer_next = ind_timer_reg;
      ind_run_next   = ind_run_reg | i_hw_start_opt;
      ind_psc_next   = ind_psc_reg;
      ind_cnt_next   = ind_cnt_reg;
      ind_tick       = 1'b0;
      ind_ev         = 2'b00;
      ind_rst        = 1'b0;
      // Low power is deliberately not looked at here: the RC tick keeps going
      if (ind_run_reg && i_lsi_tick
          && !(i_dbg_halt && dbg_reg[DWU_DBG_IND_BIT])) begin
         if (ind_psc_reg == ind_pre_reg) begin
            ind_psc_next = 8'h00;
            ind_tick     = 1'b1;
         end else begin
            ind_psc_next = ind_psc_reg + 8'h01;
         end
      end
      if (ind_tick) begin
         if (ind_cnt_reg == 12'h000) begin
            ind_cnt_next = ind_rld_reg;
            if (ind_timer_reg) begin
               ind_ev[DWU_INT_IND_TMO_BIT] = 1'b1;
            end else begin
               ind_rst = 1'b1;
            end
         end else begin
            ind_cnt_next = ind_cnt_reg - 12'h001;
         end
      end
      if (wr) begin
         unique case (i_apb.paddr)
            DWU_IND_KEY_OFS: begin
               if (i_apb.pwdata[15:0] == DWU_KEY_START) begin
                  ind_run_next = 1'b1;
                  ind_cnt_next = ind_rld_reg;
                  ind_psc_next = 8'h00;
               end else if (i_apb.pwdata[15:0] == DWU_KEY_RELOAD) begin
                  ind_cnt_next = ind_rld_reg;
               end
            end
            DWU_IND_PRE_OFS: ind_pre_next = i_apb.pwdata[7:0];
            DWU_IND_RLD_OFS: begin
               // Timer mode sits above the 12-bit reload so every reload value stays usable
               ind_rld_next   = i_apb.pwdata[11:0];
               ind_timer_next = i_apb.pwdata[DWU_IND_CFG_TIMER_BIT];
            end
            default: ;
         endcase
      end
   end

   // Window watchdog
   // Kept apart from the independent side: its clock source differs in silicon
   always_comb begin
      win_en_next   = win_en_reg;
      win_ev        = 2'b00;
      win_rst       = 1'b0;
      win_free_next = win_free_reg;
      win_win_next  = win_win_reg;
      win_cnt_next  = win_cnt_reg;
      win_div_next  = win_div_reg;
      win_step      = 1'b0;
      // Stops with the system clock in low power, unlike the independent side
      if (win_en_reg && !i_low_power
          && !(i_dbg_halt && dbg_reg[DWU_DBG_WIN_BIT])) begin
         if (win_div_reg == 32'(WIN_STEP_CYC - 1)) begin
            win_div_next = 32'h0000_0000;
            win_step     = 1'b1;
         end else begin
            win_div_next = win_div_reg + 32'h0000_0001;
         end
      end
      if (win_step) begin
         win_cnt_next = win_cnt_reg - 7'h01;
         if (win_cnt_reg == DWU_WIN_EWI_VAL + 7'h01) begin
            win_ev[DWU_INT_WIN_EWI_BIT] = 1'b1;
         end
         if (win_cnt_reg == DWU_WIN_EWI_VAL && !win_free_reg) begin
            win_rst = 1'b1;
         end
      end
      if (wr) begin
         unique case (i_apb.paddr)
            DWU_WIN_CTRL_OFS: begin
               if (win_en_reg && !win_free_reg && win_cnt_reg > win_win_reg) begin
                  win_rst = 1'b1;
               end
               win_cnt_next = i_apb.pwdata[6:0];
               win_en_next  = win_en_reg | i_apb.pwdata[DWU_WIN_EN_BIT];
               win_div_next = 32'h0000_0000;
            end
            DWU_WIN_CFG_OFS: begin
               win_win_next  = i_apb.pwdata[6:0];
               win_free_next = i_apb.pwdata[DWU_WIN_FREE_BIT];
            end
            default: ;
         endcase
      end
   end

   // Bus slave and interrupt
   always_comb begin
      dbg_next      = dbg_reg;
      int_mask_next = int_mask_reg;
      stat_clr      = 1'b0;
      ev_set        = ind_ev | win_ev;
      rst_req_next  = ind_rst | win_rst;
      pready_next   = acc;
      prdata_next   = 32'h0000_0000;
      pslverr_next  = 1'b0;
      if (wr) begin
         unique case (i_apb.paddr)
            DWU_DBG_OFS:      dbg_next      = i_apb.pwdata[1:0];
            DWU_INT_MASK_OFS: int_mask_next = i_apb.pwdata[1:0];
            DWU_IND_KEY_OFS, DWU_IND_PRE_OFS, DWU_IND_RLD_OFS,
            DWU_WIN_CTRL_OFS, DWU_WIN_CFG_OFS, DWU_IND_STAT_OFS, DWU_INT_STAT_OFS: ;
            default: pslverr_next = 1'b1;
         endcase
      end
      if (rd) begin
         unique case (i_apb.paddr)
            DWU_IND_KEY_OFS:  prdata_next = 32'h0000_0000;
            DWU_IND_PRE_OFS:  prdata_next = {24'h000000, ind_pre_reg};
            DWU_IND_RLD_OFS:  prdata_next = {19'h00000, ind_timer_reg, ind_rld_reg};
            DWU_IND_STAT_OFS: prdata_next = {19'h00000, ind_run_reg, ind_cnt_reg};
            DWU_WIN_CTRL_OFS: prdata_next = {24'h000000, win_en_reg, win_cnt_reg};
            DWU_WIN_CFG_OFS:  prdata_next = {24'h000000, win_free_reg, win_win_reg};
            DWU_DBG_OFS:      prdata_next = {30'h00000000, dbg_reg};
            DWU_INT_STAT_OFS: begin
               prdata_next   = {30'h00000000, int_stat_reg};
               stat_clr      = 1'b1;
            end
            DWU_INT_MASK_OFS: prdata_next = {30'h00000000, int_mask_reg};
            default:          pslverr_next = 1'b1;
         endcase
      end
      irq_next      = |(int_stat_next & int_mask_reg);
   end

   // One sticky bit per event source; a new event in the read-clear cycle wins
   for (genvar g = 0; g < 2; g++) begin : g_stat
      always_comb begin
         stat_bit_next[g] = int_stat_reg[g];
         if (stat_clr) begin
            stat_bit_next[g] = 1'b0;
         end
         if (ev_set[g]) begin
            stat_bit_next[g] = 1'b1;
         end
      end
   end
   assign int_stat_next = {stat_bit_next[1], stat_bit_next[0]};

   // Independent watchdog state
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ind_pre_reg   <= DWU_IND_PRE_RST;
         ind_rld_reg   <= DWU_IND_RLD_RST;
         ind_timer_reg <= 1'b0;
         ind_run_reg   <= 1'b0;
         ind_psc_reg   <= 8'h00;
         ind_cnt_reg   <= DWU_IND_RLD_RST;
      end else begin
         ind_pre_reg   <= ind_pre_next;
         ind_rld_reg   <= ind_rld_next;
         ind_timer_reg <= ind_timer_next;
         ind_run_reg   <= ind_run_next;
         ind_psc_reg   <= ind_psc_next;
         ind_cnt_reg   <= ind_cnt_next;
      end
   end

   // Window watchdog state
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         win_en_reg    <= 1'b0;
         win_free_reg  <= 1'b0;
         win_win_reg   <= DWU_WIN_WIN_RST;
         win_cnt_reg   <= DWU_WIN_CNT_RST;
         win_div_reg   <= 32'h0000_0000;
      end else begin
         win_en_reg    <= win_en_next;
         win_free_reg  <= win_free_next;
         win_win_reg   <= win_win_next;
         win_cnt_reg   <= win_cnt_next;
         win_div_reg   <= win_div_next;
      end
   end

   // Bus, interrupt and reset request state
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         dbg_reg       <= 2'b00;
         int_stat_reg  <= 2'b00;
         int_mask_reg  <= 2'b00;
         pready_reg    <= 1'b0;
         prdata_reg    <= 32'h0000_0000;
         pslverr_reg   <= 1'b0;
         irq_reg       <= 1'b0;
         rst_req_reg   <= 1'b0;
      end else begin
         dbg_reg       <= dbg_next;
         int_stat_reg  <= int_stat_next;
         int_mask_reg  <= int_mask_next;
         pready_reg    <= pready_next;
         prdata_reg    <= prdata_next;
         pslverr_reg   <= pslverr_next;
         irq_reg       <= irq_next;
         rst_req_reg   <= rst_req_next;
      end
   end

   assign o_pready  = pready_reg;
   assign o_prdata  = prdata_reg;
   assign o_pslverr = pslverr_reg;
   assign o_irq     = irq_reg;
   assign o_rst_req = rst_req_reg;
endmodule

/* sim/dwu_top_assertions.sv */
// Port checker for dwu_top: APB answer timing, reset pulse, read widths.
// Assumes one system clock and the synchronous active-high reset.
`timescale 1ns/1ns
module dwu_top_assertions
   import dwu_pkg::*;
(
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire dwu_apb_req_t i_apb,
   input  wire logic         i_lsi_tick,
   input  wire logic         i_hw_start_opt,
   input  wire logic         i_dbg_halt,
   input  wire logic         i_low_power,
   input  wire logic         o_pready,
   input  wire logic [31:0]  o_prdata,
   input  wire logic         o_pslverr,
   input  wire logic         o_irq,
   input  wire logic         o_rst_req
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire acc = i_apb.psel && i_apb.penable && !o_pready;
   wire bad = i_apb.paddr > 8'h20 || i_apb.paddr[1:0] != 2'b00;
   sequence s_rd(a);
      acc && !i_apb.pwrite && i_apb.paddr == a ##1 o_pready;
   endsequence
   a_reset_quiet: assert property ($fell(i_rst) |-> !o_rst_req && !o_irq && !o_pready)
      else $error("outputs busy after reset");
   a_ready_next: assert property (acc |=> o_pready) else $error("ready late");
   a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
   a_rst_pulse: assert property (o_rst_req |=> !o_rst_req)
      else $error("reset request too long");
   a_err_unmapped: assert property (acc && bad |=> o_pslverr) else $error("no slave error");
   a_err_mapped: assert property (acc && !bad |=> !o_pslverr) else $error("false slave error");
   a_data_idle: assert property (!o_pready |-> o_prdata == 32'h0) else $error("stray read data");
   a_key_zero: assert property (s_rd(DWU_IND_KEY_OFS) |-> o_prdata == 32'h0)
      else $error("key reads nonzero");
   a_ind_width: assert property (s_rd(DWU_IND_STAT_OFS) |-> o_prdata[31:13] == 19'h0)
      else $error("independent counter too wide");
   a_win_width: assert property (s_rd(DWU_WIN_CTRL_OFS) |-> o_prdata[31:8] == 24'h0)
      else $error("window counter too wide");
endmodule
bind dwu_top dwu_top_assertions u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_apb(i_apb),
   .i_lsi_tick(i_lsi_tick), .i_hw_start_opt(i_hw_start_opt), .i_dbg_halt(i_dbg_halt),
   .i_low_power(i_low_power), .o_pready(o_pready), .o_prdata(o_prdata),
   .o_pslverr(o_pslverr), .o_irq(o_irq), .o_rst_req(o_rst_req));

/* sim/dwu_top_tb.sv */
// Self-checking bench for dwu_top: registers, both watchdogs, interrupt.
// Assumes the port checker is bound; the window step is shortened to 4 clocks.
`timescale 1ns/1ns
module dwu_top_tb
   import dwu_pkg::*;
;
   logic         clk, rst, tick, hw, halt, lp, pready, pslverr, irq, rreq, err;
   dwu_apb_req_t apb;
   logic [31:0]  prdata, rd, v;
   int           mismatches = 0;
   int           check_count = 0;
   int           rcnt = 0;
   int           n, p, r, c0;
   logic [7:0]   ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
   logic [31:0]  rstv [9] = '{32'h0, 32'h0, 32'hfff, 32'hfff, 32'h7f, 32'h7f, 32'h0, 32'h0, 32'h0};

   dwu_top #(.WIN_STEP_CYC(4)) dut (.i_sys_clk(clk), .i_rst(rst), .i_apb(apb),
      .i_lsi_tick(tick), .i_hw_start_opt(hw), .i_dbg_halt(halt), .i_low_power(lp),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_irq(irq), .o_rst_req(rreq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (rreq === 1'b1) rcnt++;

   task automatic finish_test();
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp=%h seen=%h", what, exp, seen);
      end
   endtask
   // Holds the whole request until ready is sampled; bounded so a dead slave ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      apb <= '0;
      if (pready !== 1'b1) begin
         mismatches++;
         finish_test();
      end
   endtask
   // Four clocks per tick so a reset pulse is counted before the next look
   task automatic ticks(input int m);
      repeat (m) begin
         @(posedge clk) tick <= 1'b1;
         @(posedge clk) tick <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   // A wait that ran out is a failure and ends the run at once
   task automatic limit(input int cnt, input int lim);
      if (cnt >= lim) begin
         mismatches++;
         finish_test();
      end
   endtask
   task automatic do_reset(input logic h);
      rst <= 1'b1;
      hw <= h;
      lp <= 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   endtask

   initial begin
      rst = 1'b1; apb = '0; tick = 1'b0; hw = 1'b0; halt = 1'b0; lp = 1'b0;
      void'($urandom(32'h647e8985));
      do_reset(1'b0);
      foreach (ofs[i]) begin
         bus(1'b0, ofs[i], 32'h0);
         chk(rd, rstv[i], "reset value");
      end
      bus(1'b0, 8'h24, 32'h0);
      chk(err, 1'b1, "unmapped error");
      repeat (4) begin
         v = $urandom;
         bus(1'b1, DWU_IND_PRE_OFS, v);
         bus(1'b0, DWU_IND_PRE_OFS, 32'h0);
         chk(rd, {24'h0, v[7:0]}, "prescaler");
      end
      p = $urandom_range(3);
      r = $urandom_range(9, 2);
      lp <= 1'b1;
      bus(1'b1, DWU_IND_PRE_OFS, p);
      bus(1'b1, DWU_IND_RLD_OFS, r);
      bus(1'b1, DWU_IND_KEY_OFS, {16'h0, DWU_KEY_START});
      c0 = rcnt;
      repeat (3) begin
         ticks((r - 1) * (p + 1));
         bus(1'b1, DWU_IND_KEY_OFS, {16'h0, DWU_KEY_RELOAD});
      end
      chk(rcnt, c0, "serviced");
      bus(1'b1, DWU_IND_KEY_OFS, {16'h0, DWU_KEY_START});
      c0 = rcnt;
      n = 0;
      while (rcnt == c0 && n < 600) begin
         ticks(1);
         n++;
      end
      limit(n, 600);
      chk(n >= r * (p + 1) && n <= (r + 1) * (p + 1), 1, "expiry ticks");
      bus(1'b1, DWU_DBG_OFS, 32'h1);
      halt <= 1'b1;
      bus(1'b0, DWU_IND_STAT_OFS, 32'h0);
      v = rd;
      ticks(2 * (p + 1));
      bus(1'b0, DWU_IND_STAT_OFS, 32'h0);
      chk(rd, v, "independent frozen");
      halt <= 1'b0;
      // Timer mode sits in bit 12, above the reload field
      bus(1'b1, DWU_INT_MASK_OFS, 32'h2);
      bus(1'b1, DWU_IND_PRE_OFS, 32'h0);
      bus(1'b1, DWU_IND_RLD_OFS, 32'h1000 | r);
      bus(1'b1, DWU_IND_KEY_OFS, {16'h0, DWU_KEY_START});
      c0 = rcnt;
      n = 0;
      while (irq !== 1'b1 && n < 600) begin
         ticks(1);
         n++;
      end
      limit(n, 600);
      chk(n >= r && n <= (r + 1), 1, "timeout ticks");
      chk(rcnt, c0, "timer no reset");
      bus(1'b0, DWU_INT_STAT_OFS, 32'h0);
      chk(rd, 32'h2, "timeout status");
      @(posedge clk);
      chk(irq, 1'b0, "irq cleared");
      do_reset(1'b1);
      bus(1'b0, DWU_IND_STAT_OFS, 32'h0);
      chk(rd[12], 1'b1, "hardware start");
      bus(1'b1, DWU_WIN_CFG_OFS, 32'h7f);
      bus(1'b1, DWU_WIN_CTRL_OFS, 32'hc2);
      n = 0;
      while (rreq !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      limit(n, 100);
      chk(n >= 8 && n <= 13, 1, "window expiry");
      chk(irq, 1'b0, "masked irq");
      bus(1'b0, DWU_INT_STAT_OFS, 32'h0);
      chk(rd, 32'h1, "early warning");
      bus(1'b0, DWU_INT_STAT_OFS, 32'h0);
      chk(rd, 32'h0, "status read clear");
      bus(1'b1, DWU_INT_MASK_OFS, 32'h1);
      bus(1'b1, DWU_WIN_CFG_OFS, 32'hff);
      bus(1'b1, DWU_WIN_CTRL_OFS, 32'hc2);
      c0 = rcnt;
      repeat (600) @(posedge clk);
      chk(rcnt, c0, "free running");
      chk(irq, 1'b1, "warning irq");
      bus(1'b1, DWU_DBG_OFS, 32'h2);
      halt <= 1'b1;
      bus(1'b0, DWU_WIN_CTRL_OFS, 32'h0);
      v = rd;
      repeat (40) @(posedge clk);
      bus(1'b0, DWU_WIN_CTRL_OFS, 32'h0);
      chk(rd, v, "window frozen");
      halt <= 1'b0;
      lp <= 1'b1;
      bus(1'b0, DWU_WIN_CTRL_OFS, 32'h0);
      v = rd;
      repeat (40) @(posedge clk);
      bus(1'b0, DWU_WIN_CTRL_OFS, 32'h0);
      chk(rd, v, "window low power");
      lp <= 1'b0;
      bus(1'b1, DWU_WIN_CFG_OFS, 32'h50);
      bus(1'b1, DWU_WIN_CTRL_OFS, 32'hff);
      @(posedge clk);
      c0 = rcnt;
      bus(1'b1, DWU_WIN_CTRL_OFS, 32'hff);
      repeat (2) @(posedge clk);
      chk(rcnt, c0 + 1, "early service");
      finish_test();
   end
endmodule
